/* bench/lsi_lamp_model.sv */
`timescale 1ns/100ps
module lsi_lamp_model (
    // Indicator pins of the block
    input  wire logic [lsi_pkg::NUM_LEDS-1:0] i_led,
    input  wire logic [lsi_pkg::NUM_LEDS-1:0] i_led_oe,
    // Board resistor level on each pin
    input  wire logic [lsi_pkg::NUM_LEDS-1:0] i_pull,
    // Pin level and lamp state
    output logic      [lsi_pkg::NUM_LEDS-1:0] o_pin,
    output logic      [lsi_pkg::NUM_LEDS-1:0] o_lamp
);
    import lsi_pkg::*;
    // Released pin rests at its resistor level
    assign o_pin  = (i_led & i_led_oe) | (i_pull & ~i_led_oe);
    // Lamp to supply when pulled high, to ground when pulled low
    assign o_lamp = (o_pin ^ i_pull) & i_led_oe;
endmodule : lsi_lamp_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import lsi_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_arst_n;
    logic [4:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [15:0] o_rdata;
    logic [6:0]  sv;
    logic        i_nlp;
    logic        i_pkt10;
    logic        i_mode_strap;
    logic [2:0]  pull;
    logic [2:0]  pin;
    logic [2:0]  lamp;
    logic        o_crs;
    logic        o_col;
    logic        o_link;
    logic [2:0]  o_led;
    logic [2:0]  o_led_oe;
    int          fail_count = 0;
    int          total_checks = 0;

    always #4 i_clk = ~i_clk;

    // Status vector: s100 fd pd sd tx rx col
    lsi_led_status #(.TICK_CYC(10), .LINK_LOSS_MS(3), .BLINK_HALF_MS(2)) dut_u (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_speed_100(sv[6]),
        .i_full_duplex(sv[5]), .i_parallel_detect(sv[4]), .i_signal_detect(sv[3]),
        .i_nlp(i_nlp), .i_pkt10(i_pkt10), .i_tx_active(sv[2]), .i_rx_active(sv[1]),
        .i_mii_col(sv[0]), .i_mode_strap(i_mode_strap), .i_led_strap(pin),
        .o_crs(o_crs), .o_col(o_col), .o_link(o_link), .o_led(o_led), .o_led_oe(o_led_oe));

    lsi_lamp_model lamp_u (.i_led(o_led), .i_led_oe(o_led_oe), .i_pull(pull),
        .o_pin(pin), .o_lamp(lamp));

    task automatic finish_test();
        $display("CHECKS total=%0d bad=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic st(input logic [6:0] v);
        @(posedge i_clk);
        sv <= v;
    endtask : st

    task automatic pulse(input int s);
        @(posedge i_clk);
        if (s != 0) i_pkt10 <= 1'b1;
        else i_nlp <= 1'b1;
        @(posedge i_clk);
        i_pkt10 <= 1'b0;
        i_nlp   <= 1'b0;
        cyc(1);
    endtask : pulse

    task automatic wait_for(input int s, input logic v, output int n);
        n = 0;
        while ((s != 0 ? lamp[IDX_LINK] : o_link) !== v && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200) begin
            fail_count++;
            finish_test();
        end
    endtask : wait_for

    function automatic logic e_col(input logic [6:0] v);
        if (v[5] & ~v[4]) return 1'b0;
        return v[6] ? (v[2] & v[1]) : v[0];
    endfunction : e_col

    function automatic logic e_crs(input logic [6:0] v);
        return (v[5] & ~v[4]) ? v[1] : (v[2] | v[1]);
    endfunction : e_crs

    function automatic logic e_act(input logic [1:0] m, input logic [6:0] v);
        if (m == MODE_1) return v[2] | v[1];
        if (m == MODE_2) return e_col(v);
        return v[5] & ~v[4];
    endfunction : e_act

    initial begin
        logic [15:0] r;
        logic [15:0] d;
        logic [6:0]  v;
        logic [1:0]  m;
        logic [2:0]  en;
        logic [2:0]  val;
        int          n;
        logic [6:0]  cv [4] = '{7'h01, 7'h46, 7'h67, 7'h76};
        void'($urandom(32'hA515));
        {i_arst_n, i_addr, i_wdata, i_wr, i_rd, sv, i_nlp, i_pkt10} = '0;
        i_mode_strap = 1'b0;
        pull = 3'h0;
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_arst_n     <= 1'b0;
            pull         <= (k != 0) ? 3'h5 : 3'h2;
            i_mode_strap <= k[0];
            sv           <= 7'h48;
            repeat (3) @(posedge i_clk);
            i_arst_n <= 1'b1;
            cyc(4);
            chk(o_led_oe, 16'h0007);
            chk(o_led[IDX_SPEED], {15'h0000, ~pull[IDX_SPEED]});
            chk(lamp[IDX_SPEED], 1'b1);
            rd(ADDR_LED_DIRECT, r);
            chk(r, 16'h0000);
            rd(ADDR_PHY_CTRL, r);
            chk(r[MODE_LO_BIT], k[0]);
        end
        wr(5'h03, 16'hFFFF);
        rd(5'h03, r);
        chk(r, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            m = 2'($urandom_range(3, 1));
            d = 16'($urandom) & 16'hFE1F;
            d[MODE_LO_BIT] = (m == MODE_1);
            d[MODE_HI_BIT] = (m == MODE_3) | ((m == MODE_1) & 1'($urandom));
            v = (i < 4) ? cv[i] : 7'($urandom);
            wr(ADDR_PHY_CTRL, d);
            st(v);
            cyc(3);
            chk(lamp[IDX_SPEED], v[6]);
            chk(lamp[IDX_ACT], e_act(m, v));
            chk(o_col, e_col(v));
            chk(o_crs, e_crs(v));
            rd(ADDR_PHY_CTRL, r);
            chk(r & 16'hFF7F, (d & 16'hFE7F) | {7'h00, v[5] & ~v[4], 8'h00});
        end
        $display("test modes done");
        wr(ADDR_PHY_CTRL, 16'h0020);
        st(7'h48);
        wait_for(0, 1'b1, n);
        cyc(2);
        chk(lamp[IDX_LINK], 1'b1);
        st(7'h40);
        cyc(5);
        chk(o_link, 1'b1);
        wait_for(0, 1'b0, n);
        chk(n > 10, 1'b1);
        cyc(2);
        chk(lamp[IDX_LINK], 1'b0);
        st(7'h00);
        repeat (6) pulse(0);
        cyc(3);
        chk(o_link, 1'b0);
        pulse(0);
        cyc(3);
        chk(o_link, 1'b1);
        wait_for(0, 1'b0, n);
        pulse(1);
        cyc(2);
        chk(o_link, 1'b1);
        $display("test link done");
        st(7'h48);
        wr(ADDR_PHY_CTRL, 16'h0000);
        cyc(3);
        chk(lamp[IDX_LINK], 1'b1);
        st(7'h4C);
        cyc(3);
        chk(lamp[IDX_LINK], 1'b0);
        wait_for(1, 1'b1, n);
        chk(n <= 25, 1'b1);
        st(7'h48);
        cyc(2);
        st(7'h4A);
        cyc(3);
        chk(lamp[IDX_LINK], 1'b0);
        wr(ADDR_PHY_CTRL, 16'h0020);
        cyc(3);
        repeat (30) begin
            cyc(1);
            chk(lamp[IDX_LINK], 1'b1);
        end
        $display("test blink done");
        for (int i = 0; i < 6; i++) begin
            en  = (i == 0) ? 3'h7 : 3'($urandom);
            val = (i == 0) ? 3'h0 : 3'($urandom);
            wr(ADDR_LED_DIRECT, {10'h000, val, en});
            cyc(3);
            for (int j = 0; j < 3; j++) begin
                if (en[j]) chk(lamp[j], val[j]);
            end
            rd(ADDR_LED_DIRECT, r);
            chk(r & 16'h003F, {10'h000, val, en});
        end
        $display("test direct done");
        finish_test();
    end
endmodule : tb_top

/* inc/lsi_pkg.sv */
// Functional notes
// - Mode from control bits 6:5: bit5 set is mode 1, 00 mode 2, 10 mode 3.
// - Low mode bit may be loaded from a strap input instead of a write.
// - Mode 1 link indicator: on for good link, off without link, no blinking.
// - Modes 2 and 3 link indicator: on for good link, blinks on activity.
// - At 100 Mb/s link follows the internal signal-detect condition.
// - At 10 Mb/s link after seven consecutive link pulses or one valid packet.
// - Link drops only when the link loss timer expires, not at once.
// - Speed indicator on at 100 Mb/s, off at 10 Mb/s, in every mode.
// - Mode 1 shared indicator shows transmit or receive activity.
// - Mode 2 shared indicator shows collision status.
// - Mode 3 shared indicator shows full duplex on, half duplex off.
// - At 10 Mb/s half duplex the collision indication comes from MII COL.
// - Strap level at reset sets polarity: low gives active high, high active low.
// - Direct-control register drives indicators; reads never return pin states.
// - Half duplex: carrier sense asserts for transmit and receive activity.
// - Full duplex: collision disabled, carrier sense follows receive only.
// - A link resolved by parallel detection runs half duplex.
package lsi_pkg;
    localparam int          ADDR_W          = 5;
    localparam int          DATA_W          = 16;
    localparam logic [4:0]  ADDR_LED_DIRECT = 5'h18;
    localparam logic [4:0]  ADDR_PHY_CTRL   = 5'h19;
    localparam logic [15:0] PHY_CTRL_RST    = 16'h0000;
    localparam logic [5:0]  LED_DIRECT_RST  = 6'h00;
    localparam logic [15:0] PHY_CTRL_RO     = 16'h0180;
    localparam int          MODE_LO_BIT     = 5;
    localparam int          MODE_HI_BIT     = 6;
    localparam int          LINK_STAT_BIT   = 7;
    localparam int          DUPLEX_STAT_BIT = 8;
    localparam int          NUM_LEDS        = 3;
    localparam int          DC_EN_LSB       = 0;
    localparam int          DC_VAL_LSB      = 3;
    localparam int          IDX_LINK        = 0;
    localparam int          IDX_SPEED       = 1;
    localparam int          IDX_ACT         = 2;
    localparam logic [1:0]  MODE_1          = 2'h1;
    localparam logic [1:0]  MODE_2          = 2'h2;
    localparam logic [1:0]  MODE_3          = 2'h3;
    localparam logic [2:0]  NLP_MIN         = 3'h7;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          TICK_NS         = 1000000;
    localparam int          TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
    localparam int          LINK_LOSS_MS    = 50;
    localparam int          BLINK_HALF_MS   = 50;
endpackage : lsi_pkg

/* verilog/lsi_led_status.sv */
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module lsi_led_status #(
    parameter int TICK_CYC      = lsi_pkg::TICK_CYC,
    parameter int LINK_LOSS_MS  = lsi_pkg::LINK_LOSS_MS,
    parameter int BLINK_HALF_MS = lsi_pkg::BLINK_HALF_MS
) (
    // Clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_arst_n,
    // Register port
    input  wire logic [lsi_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [lsi_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [lsi_pkg::DATA_W-1:0]   o_rdata,
    // Port status
    input  wire logic                         i_speed_100,
    input  wire logic                         i_full_duplex,
    input  wire logic                         i_parallel_detect,
    input  wire logic                         i_signal_detect,
    input  wire logic                         i_nlp,
    input  wire logic                         i_pkt10,
    input  wire logic                         i_tx_active,
    input  wire logic                         i_rx_active,
    input  wire logic                         i_mii_col,
    // Straps
    input  wire logic                         i_mode_strap,
    input  wire logic [lsi_pkg::NUM_LEDS-1:0] i_led_strap,
    // MII status
    output logic                              o_crs,
    output logic                              o_col,
    output logic                              o_link,
    // Indicator pins
    output logic      [lsi_pkg::NUM_LEDS-1:0] o_led,
    output logic      [lsi_pkg::NUM_LEDS-1:0] o_led_oe
);
    import lsi_pkg::*;

    localparam int TW = $clog2(TICK_CYC + 1);
    localparam int LW = $clog2(LINK_LOSS_MS + 1);
    localparam int BW = $clog2(BLINK_HALF_MS + 1);

    typedef struct packed {
        logic                strap_done;
        logic [NUM_LEDS-1:0] pol;
        logic [15:0]         phy_ctrl;
        logic [5:0]          led_direct;
        logic [15:0]         rdata;
        logic [TW-1:0]       tick_cnt;
        logic [2:0]          nlp_cnt;
        logic                link;
        logic [LW-1:0]       loss_ms;
        logic                act_d;
        logic [BW-1:0]       blink_ms;
        logic                blink_on;
        logic [NUM_LEDS-1:0] led;
        logic [NUM_LEDS-1:0] led_oe;
        logic                crs;
        logic                col;
    } lsi_state_s;

    lsi_state_s          s_r;
    lsi_state_s          s_nxt;
    logic                tick;
    logic [1:0]          mode;
    logic                dup_eff;
    logic                act;
    logic                col_int;
    logic                evidence;
    logic                loss_exp;
    logic [NUM_LEDS-1:0] func;
    logic [NUM_LEDS-1:0] drive;

    // Millisecond enable pulse
    assign tick = (s_r.tick_cnt == TW'(TICK_CYC - 1));

    // Mode decode
    always_comb begin
        if (s_r.phy_ctrl[MODE_LO_BIT]) begin
            mode = MODE_1;
        end else if (s_r.phy_ctrl[MODE_HI_BIT]) begin
            mode = MODE_3;
        end else begin
            mode = MODE_2;
        end
    end

    // Parallel detection cannot learn full duplex
    assign dup_eff  = i_full_duplex & ~i_parallel_detect;
    assign act      = i_tx_active | i_rx_active;
    assign evidence = i_speed_100 ? i_signal_detect : (i_nlp | i_pkt10);
    assign loss_exp = tick && (s_r.loss_ms == LW'(LINK_LOSS_MS - 1));

    // Collision source: none in full duplex, COL at 10 Mb/s, overlap at 100 Mb/s
    always_comb begin
        if (dup_eff) begin
            col_int = 1'b0;
        end else if (i_speed_100) begin
            col_int = i_tx_active & i_rx_active;
        end else begin
            col_int = i_mii_col;
        end
    end

    // Mode-selected indicator functions
    always_comb begin
        func[IDX_SPEED] = i_speed_100;
        if (mode == MODE_1) begin
            func[IDX_LINK] = s_r.link;
            func[IDX_ACT]  = act;
        end else begin
            func[IDX_LINK] = s_r.link & (~act | s_r.blink_on);
            if (mode == MODE_2) begin
                func[IDX_ACT] = col_int;
            end else begin
                func[IDX_ACT] = dup_eff;
            end
        end
    end

    // Direct override, then strap polarity
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LEDS; gi++) begin : g_led
            assign drive[gi] = (s_r.led_direct[DC_EN_LSB+gi]
                                ? s_r.led_direct[DC_VAL_LSB+gi]
                                : func[gi]) ^ s_r.pol[gi];
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick_cnt = tick ? '0 : TW'(s_r.tick_cnt + 1'b1);

        // Strap capture in the first cycle after reset release
        if (!s_r.strap_done) begin
            s_nxt.strap_done            = 1'b1;
            s_nxt.pol                   = i_led_strap;
            s_nxt.phy_ctrl[MODE_LO_BIT] = i_mode_strap;
        end

        // Link qualification
        if (i_speed_100) begin
            s_nxt.nlp_cnt = '0;
            if (i_signal_detect) begin
                s_nxt.link = 1'b1;
            end
        end else begin
            if (i_nlp && s_r.nlp_cnt != NLP_MIN) begin
                s_nxt.nlp_cnt = s_r.nlp_cnt + 3'h1;
            end
            if (i_pkt10 || (i_nlp && s_r.nlp_cnt >= NLP_MIN - 3'h1)) begin
                s_nxt.link = 1'b1;
            end
        end

        // Link loss timer
        if (evidence) begin
            s_nxt.loss_ms = '0;
        end else if (loss_exp) begin
            s_nxt.loss_ms = '0;
            s_nxt.link    = 1'b0;
            s_nxt.nlp_cnt = '0;
        end else if (tick) begin
            s_nxt.loss_ms = LW'(s_r.loss_ms + 1'b1);
        end

        // Activity blink
        s_nxt.act_d = act;
        if (!act) begin
            s_nxt.blink_ms = '0;
            s_nxt.blink_on = 1'b1;
        end else if (!s_r.act_d) begin
            s_nxt.blink_ms = '0;
            s_nxt.blink_on = 1'b0;
        end else if (tick) begin
            if (s_r.blink_ms == BW'(BLINK_HALF_MS - 1)) begin
                s_nxt.blink_ms = '0;
                s_nxt.blink_on = ~s_r.blink_on;
            end else begin
                s_nxt.blink_ms = BW'(s_r.blink_ms + 1'b1);
            end
        end

        // MII carrier sense and collision
        s_nxt.crs = dup_eff ? i_rx_active : act;
        s_nxt.col = col_int;

        // Indicator pins
        s_nxt.led    = drive;
        s_nxt.led_oe = {NUM_LEDS{s_r.strap_done}};

        // Register writes
        if (i_wr) begin
            case (i_addr)
                ADDR_LED_DIRECT: begin
                    s_nxt.led_direct = i_wdata[5:0];
                end
                ADDR_PHY_CTRL: begin
                    s_nxt.phy_ctrl = i_wdata & ~PHY_CTRL_RO;
                end
                default: begin
                end
            endcase
        end

        // Register reads, data in the following cycle
        s_nxt.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                ADDR_LED_DIRECT: begin
                    s_nxt.rdata = {10'h000, s_r.led_direct};
                end
                ADDR_PHY_CTRL: begin
                    s_nxt.rdata                  = s_r.phy_ctrl;
                    s_nxt.rdata[LINK_STAT_BIT]   = s_r.link;
                    s_nxt.rdata[DUPLEX_STAT_BIT] = dup_eff;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r            <= '0;
            s_r.phy_ctrl   <= PHY_CTRL_RST;
            s_r.led_direct <= LED_DIRECT_RST;
            s_r.blink_on   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata  = s_r.rdata;
    assign o_crs    = s_r.crs;
    assign o_col    = s_r.col;
    assign o_link   = s_r.link;
    assign o_led    = s_r.led;
    assign o_led_oe = s_r.led_oe;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence seq_act_start;
        act && !s_r.act_d;
    endsequence

    sequence seq_steady_mode1;
        s_r.strap_done && mode == MODE_1 && !s_r.led_direct[DC_EN_LSB+IDX_LINK];
    endsequence

    property p_mode_decode;
        i_wr && i_addr == ADDR_PHY_CTRL
            |=> mode == ($past(i_wdata[MODE_LO_BIT]) ? MODE_1
                         : ($past(i_wdata[MODE_HI_BIT]) ? MODE_3 : MODE_2));
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("Mode does not follow the written control bits");

    property p_mode1_link;
        seq_steady_mode1 |=> o_led[IDX_LINK] == ($past(s_r.link) ^ $past(s_r.pol[IDX_LINK]));
    endproperty
    a_mode1_link: assert property (p_mode1_link)
        else $error("Mode 1 link indicator does not follow link");

    property p_sd_link;
        i_speed_100 && i_signal_detect |=> s_r.link ##1 s_r.link || !$past(i_signal_detect);
    endproperty
    a_sd_link: assert property (p_sd_link)
        else $error("Signal detect did not bring link up");

    property p_nlp_link;
        !i_speed_100 && (i_pkt10 || (i_nlp && s_r.nlp_cnt == 3'h6)) && !loss_exp
            |=> s_r.link;
    endproperty
    a_nlp_link: assert property (p_nlp_link)
        else $error("Seventh link pulse or packet did not raise link");

    property p_link_hold;
        s_r.link && !loss_exp |=> s_r.link;
    endproperty
    a_link_hold: assert property (p_link_hold)
        else $error("Link dropped before the loss timer expired");

    property p_speed_led;
        s_r.strap_done && !s_r.led_direct[DC_EN_LSB+IDX_SPEED]
            |=> o_led[IDX_SPEED] == ($past(i_speed_100) ^ $past(s_r.pol[IDX_SPEED]));
    endproperty
    a_speed_led: assert property (p_speed_led)
        else $error("Speed indicator wrong");

    property p_col10;
        !dup_eff && !i_speed_100 |=> o_col == $past(i_mii_col);
    endproperty
    a_col10: assert property (p_col10)
        else $error("10 Mb/s half duplex collision not from COL");

    property p_fdx;
        dup_eff |=> !o_col && o_crs == $past(i_rx_active);
    endproperty
    a_fdx: assert property (p_fdx)
        else $error("Full duplex collision or carrier sense wrong");

    property p_hdx_crs;
        !dup_eff && act |=> o_crs;
    endproperty
    a_hdx_crs: assert property (p_hdx_crs)
        else $error("Half duplex carrier sense missed activity");

    property p_strap_pol;
        $rose(s_r.strap_done) |-> s_r.pol == $past(i_led_strap) ##1 o_led_oe == '1;
    endproperty
    a_strap_pol: assert property (p_strap_pol)
        else $error("Polarity not captured from strap");

    property p_blink_restart;
        seq_act_start ##1 act [*2] |-> !s_r.blink_on || $past(tick);
    endproperty
    a_blink_restart: assert property (p_blink_restart)
        else $error("Blink period not restarted on new activity");

    property p_override;
        s_r.strap_done && s_r.led_direct[DC_EN_LSB+IDX_ACT]
            |=> o_led[IDX_ACT] == ($past(s_r.led_direct[DC_VAL_LSB+IDX_ACT])
                                   ^ $past(s_r.pol[IDX_ACT]));
    endproperty
    a_override: assert property (p_override)
        else $error("Direct control did not override indicator");

    property p_mode2_col;
        s_r.strap_done && mode == MODE_2 && !s_r.led_direct[DC_EN_LSB+IDX_ACT]
            |=> o_led[IDX_ACT] == (o_col ^ $past(s_r.pol[IDX_ACT]));
    endproperty
    a_mode2_col: assert property (p_mode2_col)
        else $error("Mode 2 shared indicator does not show collision");

    property p_mode3_dup;
        s_r.strap_done && mode == MODE_3 && !s_r.led_direct[DC_EN_LSB+IDX_ACT]
            |=> o_led[IDX_ACT] == ($past(i_full_duplex & ~i_parallel_detect)
                                   ^ $past(s_r.pol[IDX_ACT]));
    endproperty
    a_mode3_dup: assert property (p_mode3_dup)
        else $error("Mode 3 shared indicator does not show duplex");

    property p_rd_direct;
        i_rd && i_addr == ADDR_LED_DIRECT |=> o_rdata == {10'h000, $past(s_r.led_direct)};
    endproperty
    a_rd_direct: assert property (p_rd_direct)
        else $error("Direct control readback is not the stored value");

    property p_pd_half;
        i_parallel_detect && act |=> o_crs;
    endproperty
    a_pd_half: assert property (p_pd_half)
        else $error("Parallel detect link not treated as half duplex");
endmodule : lsi_led_status
